// >>> include/palette_consts.svh
// Purpose: constants for the colour lookup port
// Assumes: single 50 MHz core clock
// Notes:   selects are {reg_select_lo, reg_select_hi}
`ifndef PALETTE_CONSTS_SVH
`define PALETTE_CONSTS_SVH
`define SEL_ADDR_WR   2'h0
`define SEL_MASK      2'h1
`define SEL_COLOUR    2'h2
`define SEL_ADDR_RD   2'h3
`define COLOUR_W      6
`define PIPE_STAGES   3
`define MASK_RESET    8'h00
`define ADDR_RESET    8'h00
`define FIFO_DEPTH    4
`endif

// >>> include/palette_pkg.sv
// Purpose: shared types for the colour lookup port
// Assumes: nothing
// Notes:   one write event travels as a struct through the fifo
package palette_pkg;
   typedef struct packed {
      logic [1:0] sel;
      logic [7:0] data;
   } host_wr_s;
   typedef struct packed {
      logic [5:0] red;
      logic [5:0] green;
      logic [5:0] blue;
   } colour_s;
endpackage : palette_pkg

// >>> sim/colour_palette_port_properties.sv
// Purpose: concurrent checks on the colour lookup port pins
// Assumes: one clock domain, reset active low
// Notes:   bound to every instance of the port
`include "palette_consts.svh"
module colour_palette_port_properties #(
   parameter int ENTRIES = 256
) (
   input wire logic       core_clk_in,
   input wire logic       resetn_in,
   input wire logic [7:0] pixel_index_in,
   input wire logic       blank_n_in,
   input wire logic [5:0] red_code_out,
   input wire logic [5:0] green_code_out,
   input wire logic [5:0] blue_code_out,
   input wire logic       rd_n_in,
   input wire logic       wr_n_in,
   input wire logic       reg_select_lo_in,
   input wire logic       reg_select_hi_in,
   input wire logic [7:0] host_data_in,
   input wire logic [7:0] host_data_out,
   input wire logic       host_data_oe_out,
   input wire logic       fifo_ready_out
);
   // ---------------------------------------------
   // helpers and properties
   // ---------------------------------------------
   default clocking dc @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   logic colour_sel;
   logic zero;
   // decoded select and all-black codes
   assign colour_sel = ({reg_select_lo_in, reg_select_hi_in} == `SEL_COLOUR);
   assign zero = ((red_code_out | green_code_out | blue_code_out) == 6'h00);
   read_drive_a: assert property (!rd_n_in && !$past(rd_n_in) |-> host_data_oe_out)
      else $error("data not driven during read");
   bus_release_a: assert property ($past(rd_n_in) && $past(wr_n_in) |-> !host_data_oe_out)
      else $error("data driven with both strobes high");
   write_quiet_a: assert property (!wr_n_in && rd_n_in && $past(rd_n_in) |-> !host_data_oe_out)
      else $error("data driven during write");
   read_end_a: assert property ($rose(rd_n_in) |=> !host_data_oe_out)
      else $error("data still driven after read");
   blank_zero_a: assert property (!blank_n_in |-> ##3 zero)
      else $error("codes not zero while blanked");
   blank_pipe_a: assert property (!blank_n_in [*3] ##1 blank_n_in |-> zero ##1 zero ##1 zero)
      else $error("blank pipeline depth wrong");
   upper_zero_a: assert property (!rd_n_in && colour_sel |=> host_data_out[7:6] == 2'h0)
      else $error("colour read upper bits set");
   fifo_drain_a: assert property (wr_n_in [*8] |-> fifo_ready_out)
      else $error("write fifo not drained");
   // main scenarios reached
   cover property ($rose(wr_n_in));
   cover property ($rose(rd_n_in) && colour_sel);
   cover property ($rose(blank_n_in));
endmodule : colour_palette_port_properties

bind colour_palette_port colour_palette_port_properties #(.ENTRIES(ENTRIES)) chk_u (.*);

// >>> sim/colour_palette_port_tb_top.sv
// Purpose: self-checking bench for the colour lookup port
// Assumes: 50 MHz clock, inputs driven on falling edges
// Notes:   host cycles spaced six clocks, above the minimum
`include "palette_consts.svh"
module colour_palette_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------
   // signals and instances
   // ---------------------------------------------
   logic clk = 1'b0, rst_n = 1'b0, blank_n = 1'b0, rd_n = 1'b1, wr_n = 1'b1, hen = 1'b0;
   logic [7:0] pix = 8'h00, hdrive = 8'h00, line, dout, d;
   logic [1:0] sel = 2'h0;
   logic [5:0] red, green, blue;
   logic oe, fready;
   int fails = 0, compares = 0;
   logic [7:0] tab [6] = '{8'h41, 8'h22, 8'hff, 8'h0a, 8'h15, 8'h3c};
   colour_palette_port dut_u (.core_clk_in(clk), .resetn_in(rst_n), .pixel_index_in(pix),
      .blank_n_in(blank_n), .red_code_out(red), .green_code_out(green), .blue_code_out(blue),
      .rd_n_in(rd_n), .wr_n_in(wr_n), .reg_select_lo_in(sel[1]), .reg_select_hi_in(sel[0]),
      .host_data_in(line), .host_data_out(dout), .host_data_oe_out(oe),
      .fifo_ready_out(fready));
   host_bus_model bus_u (.oe_in(oe), .dev_data_in(dout), .host_en_in(hen),
      .host_data_in(hdrive), .line_out(line));
   // free-running clock
   initial begin
      forever #10 clk = ~clk;
   end
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus_write(input logic [1:0] s, input logic [7:0] v, input logic skew = 1'b0);
      @(negedge clk);
      sel = s;
      hdrive = v;
      hen = 1'b1;
      wr_n = 1'b0;
      @(negedge clk);
      // selects need only last past the first edge after the fall
      if (skew) begin
         sel = ~s;
      end
      repeat (3) @(negedge clk);
      wr_n = 1'b1;
      repeat (6) @(negedge clk);
      hen = 1'b0;
   endtask : bus_write
   task automatic bus_read(input logic [1:0] s, output logic [7:0] v);
      @(negedge clk);
      sel = s;
      rd_n = 1'b0;
      repeat (3) @(negedge clk);
      v = line;
      rd_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask : bus_read
   // index and blank held one clock only, codes looked at three edges later
   task automatic pix_check(input logic [7:0] idx, input logic [7:0] nxt, input logic bl,
                            input logic [17:0] exp);
      @(negedge clk);
      pix = idx;
      blank_n = bl;
      @(negedge clk);
      pix = nxt;
      blank_n = 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({red, green, blue}, exp);
   endtask : pix_check
   task automatic report_and_stop();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      check({16'h0, oe, fready}, 18'h1);
      @(negedge clk);
      rst_n = 1'b1;
      // palette loaded while blanked
      bus_write(`SEL_MASK, 8'h00);
      bus_write(`SEL_ADDR_WR, 8'h05);
      for (int i = 0; i < 6; i++) bus_write(`SEL_COLOUR, tab[i]);
      bus_write(`SEL_ADDR_RD, 8'h05);
      for (int i = 0; i < 6; i++) begin
         bus_read(`SEL_COLOUR, d);
         check({10'h0, d}, {10'h0, tab[i] & 8'h3f});
      end
      check({17'h0, oe}, 18'h0);
      pix_check(8'h05, 8'h06, 1'b1, {6'h01, 6'h22, 6'h3f});
      bus_write(`SEL_MASK, 8'h01, 1'b1);
      bus_read(`SEL_MASK, d);
      check({10'h0, d}, 18'h01);
      pix_check(8'h07, 8'h05, 1'b1, {6'h0a, 6'h15, 6'h3c});
      pix_check(8'h07, 8'h07, 1'b0, 18'h0);
      report_and_stop();
   end
   // hang guard, far beyond the expected few microseconds
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
endmodule : colour_palette_port_tb_top

// >>> sim/host_bus_model.sv
// Purpose: shared host data byte between host and device
// Assumes: no pull resistors on the byte
// Notes:   an undriven byte inverts, so stale data never matches
module host_bus_model (
   // drivers
   input  wire logic       oe_in,
   input  wire logic [7:0] dev_data_in,
   input  wire logic       host_en_in,
   input  wire logic [7:0] host_data_in,
   // resolved line
   output logic      [7:0] line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------
   // line resolution
   // ---------------------------------------------
   initial line_out = 8'h00;
   // device wins while enabled, else host, else float
   always @(oe_in, host_en_in, dev_data_in, host_data_in) begin
      if (oe_in) begin
         line_out = dev_data_in;
      end else if (host_en_in) begin
         line_out = host_data_in;
      end else begin
         line_out = ~line_out;
      end
   end
endmodule : host_bus_model

// >>> src/colour_palette_port.sv
// Purpose: 256-entry colour lookup with byte-wide strobed host port
// Assumes: pixel clock equals core_clk_in; host strobes are asynchronous
// Notes:   strobes pass a two-flop synchroniser; data pins are split in/out/oe
//
// How it works
// - masked pixel index addresses one palette entry
// - index and blank piped three stages
// - read strobe low drives selected register
// - blank low forces colour codes zero
// - host access works during blanking
// - write strobe rising edge captures data
// - read side effects on read rising edge
// - both strobes high releases data lines
// - selects sampled at strobe falling edge for writes and read side effects; read data follows the live selects
// - select codes pick address, colour, mask
// - triple stores then increments; read load fetches
// - colour bytes six bits, upper zero
// - mask bit set clears index bit
`include "palette_consts.svh"
module colour_palette_port
   import palette_pkg::*;
#(
   parameter int ENTRIES = 256
) (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       resetn_in,
   // video side
   input  wire logic [7:0] pixel_index_in,
   input  wire logic       blank_n_in,
   output logic      [5:0] red_code_out,
   output logic      [5:0] green_code_out,
   output logic      [5:0] blue_code_out,
   // host side
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic       reg_select_lo_in,
   input  wire logic       reg_select_hi_in,
   input  wire logic [7:0] host_data_in,
   output logic      [7:0] host_data_out,
   output logic            host_data_oe_out,
   // status
   output logic            fifo_ready_out
);
   //---------------------------------------------------------------
   // strobe synchronisers and edge detect
   //---------------------------------------------------------------
   logic [2:0] rd_sync, wr_sync, next_rd_sync, next_wr_sync;
   logic       rd_fall, rd_rise, wr_fall, wr_rise;
   // only stage 1 and 2 are inspected; stage 0 is the metastable flop
   always_comb begin
      next_rd_sync = {rd_sync[1:0], rd_n_in};
      next_wr_sync = {wr_sync[1:0], wr_n_in};
      rd_fall = rd_sync[2] && !rd_sync[1];
      rd_rise = !rd_sync[2] && rd_sync[1];
      wr_fall = wr_sync[2] && !wr_sync[1];
      wr_rise = !wr_sync[2] && wr_sync[1];
   end
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_sync <= 3'h7;
         wr_sync <= 3'h7;
      end else begin
         rd_sync <= next_rd_sync;
         wr_sync <= next_wr_sync;
      end
   end
   //---------------------------------------------------------------
   // select and data pins aligned with the strobe synchroniser
   //---------------------------------------------------------------
   host_wr_s   pins_q0, pins_q1, next_pins_q0, next_pins_q1;
   // two stages, like the strobes, so selects and data are taken as they
   // stood at the edge that saw the strobe low, not clocks later
   always_comb begin
      next_pins_q0 = '{sel: {reg_select_lo_in, reg_select_hi_in}, data: host_data_in};
      next_pins_q1 = pins_q0;
   end
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pins_q0 <= '0;
         pins_q1 <= '0;
      end else begin
         pins_q0 <= next_pins_q0;
         pins_q1 <= next_pins_q1;
      end
   end
   //---------------------------------------------------------------
   // select and write data capture
   //---------------------------------------------------------------
   logic [1:0] sel, next_sel;
   logic [7:0] wdata, next_wdata;
   // selects held from the falling edge; data taken near the rising edge
   always_comb begin
      next_sel   = sel;
      next_wdata = wdata;
      if (rd_fall || wr_fall) begin
         next_sel = pins_q1.sel;
      end
      if (!wr_sync[1]) begin
         next_wdata = pins_q1.data; // last value seen with the strobe low
      end
   end
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sel   <= 2'h0;
         wdata <= 8'h00;
      end else begin
         sel   <= next_sel;
         wdata <= next_wdata;
      end
   end
   //---------------------------------------------------------------
   // write event fifo
   //---------------------------------------------------------------
   host_wr_s fifo_in, fifo_out;
   logic     fifo_valid, fifo_in_ready, pal_busy, fifo_pop;
   assign fifo_in = '{sel: sel, data: wdata};
   // a read fetch occupies the ram port, so writes wait behind it
   assign fifo_pop = fifo_valid && !pal_busy;
   palette_fifo #(
      .WIDTH ($bits(host_wr_s)),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .core_clk_in   (core_clk_in),
      .resetn_in     (resetn_in),
      .in_valid_in   (wr_rise),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (fifo_in),
      .out_valid_out (fifo_valid),
      .out_ready_in  (!pal_busy),
      .out_data_out  (fifo_out)
   );
   //---------------------------------------------------------------
   // host register state
   //---------------------------------------------------------------
   typedef enum logic [1:0] {IDLE, FETCH} fetch_e;
   fetch_e     state, next_state;
   logic [7:0] addr, next_addr, mask, next_mask;
   colour_s    cval, next_cval;
   logic [1:0] phase, next_phase;
   logic       rd_mode, next_rd_mode;
   logic       ram_we;
   colour_s    ram_wdata, ram_rdata;
   colour_s    palette [ENTRIES];
   assign pal_busy = (state == FETCH);
   always_comb begin
      next_state   = state;
      next_addr    = addr;
      next_mask    = mask;
      next_cval    = cval;
      next_phase   = phase;
      next_rd_mode = rd_mode;
      ram_we       = 1'b0;
      ram_wdata    = cval;
      case (state)
         IDLE: begin
            if (fifo_pop) begin // host writes run regardless of blank
               case (fifo_out.sel)
                  `SEL_ADDR_WR: begin
                     next_addr    = fifo_out.data;
                     next_phase   = 2'h0;
                     next_rd_mode = 1'b0;
                  end
                  `SEL_ADDR_RD: begin
                     next_addr    = fifo_out.data;
                     next_phase   = 2'h0;
                     next_rd_mode = 1'b1;
                     next_state   = FETCH;
                  end
                  `SEL_MASK: next_mask = fifo_out.data;
                  default: begin
                     // colour byte: keep low six bits
                     case (phase)
                        2'h0:    next_cval.red   = fifo_out.data[5:0];
                        2'h1:    next_cval.green = fifo_out.data[5:0];
                        default: next_cval.blue  = fifo_out.data[5:0];
                     endcase
                     if (phase == 2'h2) begin
                        ram_we     = 1'b1;
                        ram_wdata  = '{red: cval.red, green: cval.green,
                                       blue: fifo_out.data[5:0]};
                        next_addr  = addr + 8'h01;
                        next_phase = 2'h0;
                     end else begin
                        next_phase = phase + 2'h1;
                     end
                  end
               endcase
            end else if (rd_rise && sel == `SEL_COLOUR) begin
               // read completes at the rising edge
               if (phase == 2'h2) begin
                  next_phase = 2'h0;
                  if (rd_mode) begin
                     next_state = FETCH; // next entry for successive reads
                  end
               end else begin
                  next_phase = phase + 2'h1;
               end
            end
         end
         FETCH: begin
            next_cval  = palette[addr];
            next_addr  = addr + 8'h01;
            next_state = IDLE;
         end
         default: next_state = IDLE;
      endcase
   end
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state   <= IDLE;
         addr    <= `ADDR_RESET;
         mask    <= `MASK_RESET;
         cval    <= '0;
         phase   <= 2'h0;
         rd_mode <= 1'b0;
      end else begin
         state   <= next_state;
         addr    <= next_addr;
         mask    <= next_mask;
         cval    <= next_cval;
         phase   <= next_phase;
         rd_mode <= next_rd_mode;
      end
   end
   // palette ram, host address never masked
   always_ff @(posedge core_clk_in) begin
      if (ram_we) begin
         palette[addr] <= ram_wdata;
      end
   end
   //---------------------------------------------------------------
   // video pipeline
   //---------------------------------------------------------------
   logic [7:0] idx_q, next_idx_q;
   logic [1:0] blank_q, next_blank_q;
   colour_s    look_q, next_look_q;
   colour_s    out_c, next_out_c;
   // stage 1 latch, stage 2 lookup, stage 3 output latch
   // the lookup row keeps index and blank at the same depth, so a colour
   // never reaches the pins one clock ahead of its own blank bit
   always_comb begin
      next_idx_q   = pixel_index_in & ~mask;
      next_blank_q = {blank_q[0], blank_n_in};
      ram_rdata    = palette[idx_q];
      next_look_q  = ram_rdata;
      next_out_c   = blank_q[1] ? look_q : '0;
   end
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         idx_q   <= 8'h00;
         blank_q <= 2'h0;
         look_q  <= '0;
         out_c   <= '0;
      end else begin
         idx_q   <= next_idx_q;
         blank_q <= next_blank_q;
         look_q  <= next_look_q;
         out_c   <= next_out_c;
      end
   end
   assign red_code_out   = out_c.red;
   assign green_code_out = out_c.green;
   assign blue_code_out  = out_c.blue;
   //---------------------------------------------------------------
   // host read data and pin drive
   //---------------------------------------------------------------
   logic [7:0] rdata, next_rdata;
   logic       oe, next_oe, fready, next_fready;
   // registered, so drive follows rd_n by one clock
   always_comb begin
      case ({reg_select_lo_in, reg_select_hi_in})
         `SEL_ADDR_WR, `SEL_ADDR_RD: next_rdata = addr;
         `SEL_MASK:                  next_rdata = mask;
         default: begin
            case (phase) // upper two bits zero
               2'h0:    next_rdata = {2'h0, cval.red};
               2'h1:    next_rdata = {2'h0, cval.green};
               default: next_rdata = {2'h0, cval.blue};
            endcase
         end
      endcase
      next_oe     = !rd_n_in;
      next_fready = fifo_in_ready;
   end
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata  <= 8'h00;
         oe     <= 1'b0;
         fready <= 1'b1;
      end else begin
         rdata  <= next_rdata;
         oe     <= next_oe;
         fready <= next_fready;
      end
   end
   assign host_data_out    = rdata;
   assign host_data_oe_out = oe;
   assign fifo_ready_out   = fready; // host spacing keeps this high
endmodule : colour_palette_port

// >>> src/palette_fifo.sv
// Purpose: small fifo between host write events and palette logic
// Assumes: one clock, WIDTH and DEPTH parameters, DEPTH a power of two
// Notes:   full and empty are exact; ready drops when full
module palette_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             core_clk_in,
   input  wire logic             resetn_in,
   // fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic             push, pop;
   // pointer arithmetic with an extra wrap bit
   always_comb begin
      push         = in_valid_in && in_ready_out;
      pop          = out_valid_out && out_ready_in;
      next_wr_ptr  = push ? wr_ptr + {{AW{1'b0}}, 1'b1} : wr_ptr;
      next_rd_ptr  = pop ? rd_ptr + {{AW{1'b0}}, 1'b1} : rd_ptr;
      in_ready_out  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
      out_valid_out = (wr_ptr != rd_ptr);
      out_data_out  = mem[rd_ptr[AW-1:0]];
   end
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end
   // storage has no reset; contents are don't-care until written
   always_ff @(posedge core_clk_in) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_in;
      end
   end
endmodule : palette_fifo
